// ==== srx_pkg.sv ====
// Constants shared by the serial receive status logic
package srx_pkg;
	// System clock and line rate
	localparam int        CLK_HZ       = 20000000;
	localparam int        CLK_PERIOD_NS = 50;
	localparam int        BAUD_HZ      = 9600;
	localparam int        OVERSAMPLE   = 16;
	localparam int        TICK_DIV     = CLK_HZ / (BAUD_HZ * OVERSAMPLE);
	localparam int        TICK_W       = 8;
	localparam logic [7:0] TICK_LAST   = TICK_W'(TICK_DIV - 1);

	// Oversample positions inside one bit
	localparam logic [3:0] SAMPLE_MID  = 4'h7;
	localparam logic [3:0] BIT_LAST    = 4'hf;

	// Character lengths, counted from zero
	localparam logic [3:0] BITS8_LAST  = 4'h7;
	localparam logic [3:0] BITS9_LAST  = 4'h8;

	// Receive queue
	localparam int        FIFO_DEPTH   = 2;
	localparam int        CNT_W        = 2;
	localparam logic [1:0] FIFO_EMPTY  = 2'h0;
	localparam logic [1:0] FIFO_FULL   = 2'h2;

	// Reset values
	localparam logic       LINE_IDLE   = 1'b1;
	localparam logic [7:0] DATA_RST    = 8'h00;
	localparam logic [8:0] SHIFT_RST   = 9'h000;

	// Receiver states, Gray coded along idle, start, data, stop
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_START = 2'b01,
		ST_DATA  = 2'b11,
		ST_STOP  = 2'b10
	} srx_state_t;
endpackage

// ==== srx_tick.sv ====
// Oversample tick divider for the serial receiver
`timescale 1ns/1ps
module srx_tick
	import srx_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	// Control
	input  wire logic run,
	// Tick
	output logic      tick
);
	logic [7:0] div_cnt;
	logic [7:0] next_div_cnt;
	logic       next_tick;

	// Restarting on each frame aligns the samples to the start edge
	always_comb begin
		next_div_cnt = div_cnt;
		next_tick    = 1'b0;
		if (!run) begin
			next_div_cnt = 8'h00;
		end else if (div_cnt == TICK_LAST) begin
			next_div_cnt = 8'h00;
			next_tick    = 1'b1;
		end else begin
			next_div_cnt = div_cnt + 8'h01;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_cnt <= 8'h00;
			tick    <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			tick    <= next_tick;
		end
	end
endmodule

// ==== srx_top.sv ====
// Serial receiver with two-entry queue, framing and overrun status
`timescale 1ns/1ps
// Summary of operation
// - Pending flag set when enabled and data queued
// - Pending flag is read-only, follows queue only
// - Interrupt needs all three enables set
// - Pending flag ignores the interrupt enables
// - Framing status stored with each character
// - Framing error when stop sample is low
// - Framing status shown for oldest entry
// - Reception continues after a framing error
// - Data read pops queue to next entry
// - Port disable resets receiver, clears framing
// - Receive disable keeps framing status
// - Framing error alone raises no interrupt
// - Queue holds at most two characters
// - Third complete character sets overrun, dropped
// - During overrun queue readable, nothing accepted
// - Either enable cleared clears overrun
// - Ninth bit stored and shown per entry
module srx_top
	import srx_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	// Serial line
	input  wire logic       rx_pin,
	// Control
	input  wire logic       serial_port_enable,
	input  wire logic       continuous_rx_enable,
	input  wire logic       rx9_mode,
	input  wire logic       rx_irq_enable,
	input  wire logic       peripheral_irq_enable,
	input  wire logic       global_irq_enable,
	// Data register read strobe
	input  wire logic       rx_data_rd,
	// Data and status
	output logic [7:0]      rx_data,
	output logic            rx_ninth_bit,
	output logic            framing_error_flag,
	output logic            overrun_flag,
	output logic            rx_pending_flag,
	output logic            rx_irq
);
	// Line synchroniser
	logic       rx_meta;
	logic       rx_line;

	// Receiver
	srx_state_t state;
	srx_state_t next_state;
	logic [3:0] os_cnt;
	logic [3:0] next_os_cnt;
	logic [3:0] bit_cnt;
	logic [3:0] next_bit_cnt;
	logic [8:0] shift;
	logic [8:0] next_shift;
	logic       nine;
	logic       next_nine;
	logic       tick;
	logic       rx_on;
	logic       push;

	// Queue and flags
	logic [7:0]            fifo_dat [FIFO_DEPTH];
	logic [7:0]            next_fifo_dat [FIFO_DEPTH];
	logic [FIFO_DEPTH-1:0] fifo_framing_error_flag;
	logic [FIFO_DEPTH-1:0] next_fifo_framing_error_flag;
	logic [FIFO_DEPTH-1:0] fifo_nine;
	logic [FIFO_DEPTH-1:0] next_fifo_nine;
	logic [CNT_W-1:0]      cnt;
	logic [CNT_W-1:0]      next_cnt;
	logic [CNT_W-1:0]      wr_idx;
	logic                  next_ovr;
	logic                  next_pend;
	logic                  next_irq;
	logic                  pop;
	logic                  accept;
	logic                  ovr_hit;
	logic [7:0]            char_dat;
	logic                  char_nine;
	logic                  char_framing_error_flag;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_meta <= LINE_IDLE;
			rx_line <= LINE_IDLE;
		end else begin
			rx_meta <= rx_pin;
			rx_line <= rx_meta;
		end
	end

	// Clearing the port enable also holds the receiver idle
	assign rx_on = serial_port_enable && continuous_rx_enable;

	srx_tick u_tick (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.run     (state != ST_IDLE),
		.tick    (tick)
	);

	// Receiver keeps running regardless of earlier framing errors
	always_comb begin
		next_state   = state;
		next_os_cnt  = os_cnt;
		next_bit_cnt = bit_cnt;
		next_shift   = shift;
		next_nine    = nine;
		push         = 1'b0;
		case (state)
			ST_IDLE: begin
				if (rx_on && !rx_line) begin
					next_state   = ST_START;
					next_os_cnt  = 4'h0;
					next_bit_cnt = 4'h0;
					next_nine    = rx9_mode;
				end
			end
			ST_START: begin
				if (tick) begin
					if (os_cnt == SAMPLE_MID) begin
						next_os_cnt = 4'h0;
						// A short low pulse is noise, not a start bit
						next_state  = rx_line ? ST_IDLE : ST_DATA;
					end else begin
						next_os_cnt = os_cnt + 4'h1;
					end
				end
			end
			ST_DATA: begin
				if (tick) begin
					if (os_cnt == BIT_LAST) begin
						next_os_cnt = 4'h0;
						next_shift  = {rx_line, shift[8:1]};
						if (bit_cnt == (nine ? BITS9_LAST : BITS8_LAST)) begin
							next_state = ST_STOP;
						end else begin
							next_bit_cnt = bit_cnt + 4'h1;
						end
					end else begin
						next_os_cnt = os_cnt + 4'h1;
					end
				end
			end
			ST_STOP: begin
				if (tick) begin
					if (os_cnt == BIT_LAST) begin
						push       = 1'b1;
						next_state = ST_IDLE;
					end else begin
						next_os_cnt = os_cnt + 4'h1;
					end
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		if (!rx_on) begin
			next_state = ST_IDLE;
			push       = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state   <= ST_IDLE;
			os_cnt  <= 4'h0;
			bit_cnt <= 4'h0;
			shift   <= SHIFT_RST;
			nine    <= 1'b0;
		end else begin
			state   <= next_state;
			os_cnt  <= next_os_cnt;
			bit_cnt <= next_bit_cnt;
			shift   <= next_shift;
			nine    <= next_nine;
		end
	end

	// Completed character fields
	assign char_dat  = nine ? shift[7:0] : shift[8:1];
	assign char_nine = nine && shift[8];
	assign char_framing_error_flag = !rx_line;

	// A read in the same cycle makes room, so the arrival is not an overrun
	assign pop     = rx_data_rd && (cnt != FIFO_EMPTY);
	assign accept  = push && !overrun_flag && ((cnt != FIFO_FULL) || pop);
	assign ovr_hit = push && !overrun_flag && (cnt == FIFO_FULL) && !pop;
	assign wr_idx  = cnt - {1'b0, pop};

	always_comb begin
		next_fifo_dat  = fifo_dat;
		next_fifo_framing_error_flag = fifo_framing_error_flag;
		next_fifo_nine = fifo_nine;
		next_cnt       = cnt;
		if (pop) begin
			// Emptied slots are zeroed so the head status reads clear
			for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
				next_fifo_dat[i]  = fifo_dat[i+1];
				next_fifo_framing_error_flag[i] = fifo_framing_error_flag[i+1];
				next_fifo_nine[i] = fifo_nine[i+1];
			end
			next_fifo_dat[FIFO_DEPTH-1]  = DATA_RST;
			next_fifo_framing_error_flag[FIFO_DEPTH-1] = 1'b0;
			next_fifo_nine[FIFO_DEPTH-1] = 1'b0;
			next_cnt = cnt - 2'h1;
		end
		if (accept) begin
			for (int i = 0; i < FIFO_DEPTH; i++) begin
				if (wr_idx == CNT_W'(i)) begin
					next_fifo_dat[i]  = char_dat;
					next_fifo_framing_error_flag[i] = char_framing_error_flag;
					next_fifo_nine[i] = char_nine;
				end
			end
			next_cnt = wr_idx + 2'h1;
		end
		if (!serial_port_enable) begin
			for (int i = 0; i < FIFO_DEPTH; i++) begin
				next_fifo_dat[i] = DATA_RST;
			end
			next_fifo_framing_error_flag = '0;
			next_fifo_nine = '0;
			next_cnt       = FIFO_EMPTY;
		end
		// Dropping only the receive enable leaves queued status alone
		next_ovr  = rx_on && (overrun_flag || ovr_hit);
		next_pend = serial_port_enable && (next_cnt != FIFO_EMPTY);
		// Only the pending flag feeds the request, never framing status
		next_irq  = next_pend && rx_irq_enable && peripheral_irq_enable && global_irq_enable;
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < FIFO_DEPTH; i++) begin
				fifo_dat[i] <= DATA_RST;
			end
			fifo_framing_error_flag       <= '0;
			fifo_nine       <= '0;
			cnt             <= FIFO_EMPTY;
			overrun_flag    <= 1'b0;
			rx_pending_flag <= 1'b0;
			rx_irq          <= 1'b0;
		end else begin
			fifo_dat        <= next_fifo_dat;
			fifo_framing_error_flag       <= next_fifo_framing_error_flag;
			fifo_nine       <= next_fifo_nine;
			cnt             <= next_cnt;
			overrun_flag    <= next_ovr;
			rx_pending_flag <= next_pend;
			rx_irq          <= next_irq;
		end
	end

	// Head entry; software reads status before data since the read pops
	assign rx_data            = fifo_dat[0];
	assign framing_error_flag = fifo_framing_error_flag[0];
	assign rx_ninth_bit       = fifo_nine[0];

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	pending_occupancy_a: assert property (rx_pending_flag == (cnt != FIFO_EMPTY))
		else $error("pending flag disagrees with queue occupancy");

	pending_no_enables_a: assert property (
		(serial_port_enable && accept && !rx_irq_enable) |=> rx_pending_flag)
		else $error("pending flag not set with interrupts disabled");

	irq_gate_a: assert property (
		rx_irq |-> (rx_pending_flag && $past(rx_irq_enable) && $past(peripheral_irq_enable)
			&& $past(global_irq_enable)))
		else $error("interrupt raised without all enables");

	irq_no_framing_error_flag_a: assert property (
		(!rx_pending_flag) |-> !rx_irq)
		else $error("interrupt raised with empty queue");

	framing_error_flag_stop_a: assert property (
		(accept && cnt == FIFO_EMPTY) |=> (framing_error_flag == !$past(rx_line)))
		else $error("framing status not taken from stop sample");

	entry_write_a: assert property (
		(accept && cnt == FIFO_EMPTY) |=> (rx_data == $past(char_dat) && rx_ninth_bit == $past(char_nine)))
		else $error("entry fields not written together");

	pop_advance_a: assert property (
		(pop && cnt == FIFO_FULL && !accept && serial_port_enable)
			|=> (rx_data == $past(fifo_dat[1]) && framing_error_flag == $past(fifo_framing_error_flag[1])))
		else $error("read did not advance to next entry");

	framing_error_flag_reset_a: assert property (!serial_port_enable |=> !framing_error_flag && cnt == FIFO_EMPTY)
		else $error("port disable did not clear framing status");

	framing_error_flag_keep_a: assert property (
		($fell(continuous_rx_enable) && serial_port_enable && !rx_data_rd) |=> $stable(framing_error_flag))
		else $error("receive disable changed framing status");

	depth_max_a: assert property (cnt <= FIFO_FULL)
		else $error("queue holds more than two characters");

	ovr_set_a: assert property (
		(push && cnt == FIFO_FULL && !rx_data_rd) |=> (overrun_flag && cnt == FIFO_FULL))
		else $error("third character did not set overrun");

	ovr_hold_a: assert property (
		(overrun_flag && !rx_data_rd && serial_port_enable) |=> (cnt == $past(cnt)))
		else $error("character accepted during overrun");

	ovr_clear_a: assert property (!continuous_rx_enable |=> !overrun_flag)
		else $error("overrun not cleared by receive disable");

	ovr_reset_a: assert property (!serial_port_enable |=> !overrun_flag)
		else $error("overrun not cleared by port disable");

	overrun_seen_c: cover property (ovr_hit ##1 overrun_flag);
	framing_error_flag_seen_c: cover property ((pop && fifo_framing_error_flag[1]) ##1 framing_error_flag);
	two_entries_c: cover property (cnt == FIFO_FULL ##1 pop);
	irq_seen_c: cover property ($rose(rx_irq));
endmodule

// ==== srx_line_model.sv ====
// Behavioural remote transmitter driving the serial receive line
`timescale 1ns/1ps
module srx_line_model
	import srx_pkg::*;
(
	// Clock
	input  wire logic ref_clk,
	// Serial line
	output logic      rx_line
);
	localparam int BIT_CLKS = OVERSAMPLE * TICK_DIV;

	initial rx_line = LINE_IDLE;

	task automatic hold_bit(input logic lvl);
		rx_line = lvl;
		repeat (BIT_CLKS) @(negedge ref_clk);
	endtask

	// One frame, LSB first; the caller picks the stop level to force a framing fault
	task automatic send(input logic [8:0] val, input int nbits, input logic stop_lvl);
		@(negedge ref_clk);
		hold_bit(1'b0);
		for (int i = 0; i < nbits; i++) begin
			hold_bit(val[i]);
		end
		hold_bit(stop_lvl);
		// A full idle bit after a low stop keeps it from passing for a new start
		hold_bit(LINE_IDLE);
	endtask
endmodule

// ==== serial_rx_status_errors_test.sv ====
// Self-checking bench for the serial receive status logic
`timescale 1ns/1ps
module serial_rx_status_errors_test;
	// Clock and reset
	logic       ref_clk;
	logic       sys_rst;
	// Serial line
	logic       rx_pin;
	// Control
	logic       serial_port_enable;
	logic       continuous_rx_enable;
	logic       rx9_mode;
	logic       rx_irq_enable;
	logic       peripheral_irq_enable;
	logic       global_irq_enable;
	logic       rx_data_rd;
	// Data and status
	logic [7:0] rx_data;
	logic       rx_ninth_bit;
	logic       framing_error_flag;
	logic       overrun_flag;
	logic       rx_pending_flag;
	logic       rx_irq;
	// Bookkeeping
	int         num_errors = 0;
	int         n_compared = 0;

	srx_line_model line (
		.ref_clk (ref_clk),
		.rx_line (rx_pin)
	);

	srx_top dut (
		.ref_clk               (ref_clk),
		.sys_rst               (sys_rst),
		.rx_pin                (rx_pin),
		.serial_port_enable    (serial_port_enable),
		.continuous_rx_enable  (continuous_rx_enable),
		.rx9_mode              (rx9_mode),
		.rx_irq_enable         (rx_irq_enable),
		.peripheral_irq_enable (peripheral_irq_enable),
		.global_irq_enable     (global_irq_enable),
		.rx_data_rd            (rx_data_rd),
		.rx_data               (rx_data),
		.rx_ninth_bit          (rx_ninth_bit),
		.framing_error_flag    (framing_error_flag),
		.overrun_flag          (overrun_flag),
		.rx_pending_flag       (rx_pending_flag),
		.rx_irq                (rx_irq)
	);

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// Order: ninth bit, framing, overrun, pending, irq, data
	function automatic logic [12:0] snap();
		return {rx_ninth_bit, framing_error_flag, overrun_flag, rx_pending_flag, rx_irq, rx_data};
	endfunction

	task automatic check(input logic [12:0] seen, input logic [12:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Pulses the read strobe for one cycle, then waits two cycles for the queue to advance
	task automatic read_data();
		rx_data_rd = 1'b1;
		cyc(1);
		rx_data_rd = 1'b0;
		cyc(2);
	endtask

	task automatic t_first_char();
		line.send(9'h05a, 8, 1'b1);
		check(snap(), {5'b00010, 8'h5a});
	endtask

	task automatic t_irq_gating();
		for (int m = 0; m < 8; m++) begin
			{rx_irq_enable, peripheral_irq_enable, global_irq_enable} = 3'(m);
			cyc(2);
			check(snap(), {4'b0001, m == 7, 8'h5a});
		end
	endtask

	task automatic t_framing_nine_bit();
		rx9_mode = 1'b1;
		line.send(9'h1a5, 9, 1'b0);
		rx9_mode = 1'b0;
		check(snap(), {5'b00011, 8'h5a});
	endtask

	task automatic t_overrun();
		line.send(9'h03c, 8, 1'b1);
		check(snap(), {5'b00111, 8'h5a});
		read_data();
		check(snap(), {5'b11111, 8'ha5});
	endtask

	task automatic t_rx_disable();
		continuous_rx_enable = 1'b0;
		cyc(2);
		check(snap(), {5'b11011, 8'ha5});
		continuous_rx_enable = 1'b1;
		cyc(2);
		check(snap(), {5'b11011, 8'ha5});
	endtask

	task automatic t_port_disable();
		serial_port_enable = 1'b0;
		cyc(2);
		check(snap(), 13'h0000);
		serial_port_enable = 1'b1;
		read_data();
		check(snap(), 13'h0000);
	endtask

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		sys_rst = 1'b1;
		serial_port_enable = 1'b1;
		continuous_rx_enable = 1'b1;
		rx9_mode = 1'b0;
		rx_irq_enable = 1'b0;
		peripheral_irq_enable = 1'b0;
		global_irq_enable = 1'b0;
		rx_data_rd = 1'b0;
		cyc(8);
		sys_rst = 1'b0;
		cyc(2);
		t_first_char();
		t_irq_gating();
		t_framing_nine_bit();
		t_overrun();
		t_rx_disable();
		t_port_disable();
		summarize();
	end
endmodule
